// File: pgm_defs.svh
`ifndef PGM_DEFS_SVH
`define PGM_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PGM_OFS_TWO_A    8'ha8
`define PGM_OFS_TWO_B    8'ha9
`define PGM_OFS_THREE_A  8'haa
`define PGM_OFS_STATUS   8'hb0

// ****************************************************************
// widths, reset values and mask patterns
// ****************************************************************
`define PGM_DW           8
`define PGM_ZERO         8'h00
`define PGM_ALL_MASKED   8'hff
`define PGM_CTL_ONLY     8'h0f
`define PGM_SHARED_ONLY  8'hfb

// ****************************************************************
// field positions
// ****************************************************************
`define PGM_BIT_LINEAR_A2      7
`define PGM_BIT_SWITCH_A1      6
`define PGM_STEPDOWN_HI        5
`define PGM_BIT_TERMINATION    3
`define PGM_BIT_SHARED         2
`define PGM_BIT_SWITCH_B1      1
`define PGM_BIT_LINEAR_A3      0
`define PGM_CTL_HI             7
`define PGM_CTL_LO             4
`define PGM_ST_GOOD_TWO        0
`define PGM_ST_GOOD_THREE      1
`define PGM_ST_SHARED_SEL      2
`define PGM_ST_LOADED          3

`endif

// File: pgm_pkg.sv
package pgm_pkg;

  typedef logic [7:0] pgm_byte_type;

  typedef enum logic {
    PGM_SHARED_SWITCH_B2 = 1'b0,
    PGM_SHARED_LINEAR_A1 = 1'b1
  } pgm_shared_type;

endpackage : pgm_pkg

// File: pgm_mask_reg.sv
`timescale 1ns/100ps
`include "pgm_defs.svh"

module pgm_mask_reg
  import pgm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         load_otp,
  input  wire pgm_byte_type otp_val,
  input  wire logic         wr_en,
  input  wire pgm_byte_type wdata,
  output pgm_byte_type      q
);

  pgm_byte_type mask_r;
  pgm_byte_type mask_nxt;

  // otp load wins over a software write in the same cycle
  always_comb begin
    mask_nxt = mask_r;
    if (load_otp) begin
      mask_nxt = otp_val;
    end else if (wr_en) begin
      mask_nxt = wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_r <= `PGM_ZERO;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  assign q = mask_r;

endmodule : pgm_mask_reg

// File: pgm_bank.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "pgm_defs.svh"

module pgm_bank
  import pgm_pkg::*;
(
  input  wire logic         MCLK,
  input  wire logic         RSTN,
  input  wire pgm_byte_type ADDR,
  input  wire pgm_byte_type WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output pgm_byte_type      RDATA,
  input  wire pgm_byte_type OTP_TWO_A,
  input  wire pgm_byte_type OTP_TWO_B,
  input  wire pgm_byte_type OTP_THREE_A,
  input  wire logic         OTP_SHARED_SEL,
  input  wire logic [5:0]   STEPDOWN_GOOD,
  input  wire logic         LINEAR_A2_GOOD,
  input  wire logic         SWITCH_A1_GOOD,
  input  wire logic         LINEAR_A3_GOOD,
  input  wire logic         LINEAR_A1_GOOD,
  input  wire logic         SWITCH_B1_GOOD,
  input  wire logic         SWITCH_B2_GOOD,
  input  wire logic         TERMINATION_GOOD,
  input  wire logic [3:0]   CONTROL_IN,
  output logic              POWER_GOOD_OUT_TWO,
  output logic              POWER_GOOD_OUT_THREE
);

  // ****************************************************************
  // otp load sequencing
  // ****************************************************************
  logic           loaded_r;
  logic           loaded_nxt;
  pgm_shared_type shared_sel_r;
  pgm_shared_type shared_sel_nxt;
  logic           load_otp;

  // async reset can only take constants, so otp is caught after release
  always_comb begin
    loaded_nxt     = 1'b1;
    shared_sel_nxt = shared_sel_r;
    if (!loaded_r) begin
      shared_sel_nxt = pgm_shared_type'(OTP_SHARED_SEL);
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      loaded_r     <= 1'b0;
      shared_sel_r <= PGM_SHARED_SWITCH_B2;
    end else begin
      loaded_r     <= loaded_nxt;
      shared_sel_r <= shared_sel_nxt;
    end
  end

  assign load_otp = !loaded_r;

  // ****************************************************************
  // mask registers
  // ****************************************************************
  logic         wr_two_a;
  logic         wr_two_b;
  logic         wr_three_a;
  pgm_byte_type mask_two_a;
  pgm_byte_type mask_two_b;
  pgm_byte_type mask_three_a;

  always_comb begin
    wr_two_a   = 1'b0;
    wr_two_b   = 1'b0;
    wr_three_a = 1'b0;
    if (WR && ADDR == `PGM_OFS_TWO_A) begin
      wr_two_a = 1'b1;
    end else if (WR && ADDR == `PGM_OFS_TWO_B) begin
      wr_two_b = 1'b1;
    end else if (WR && ADDR == `PGM_OFS_THREE_A) begin
      wr_three_a = 1'b1;
    end
  end

  pgm_mask_reg u_two_a (
    .clk      (MCLK),
    .rstn     (RSTN),
    .load_otp (load_otp),
    .otp_val  (OTP_TWO_A),
    .wr_en    (wr_two_a),
    .wdata    (WDATA),
    .q        (mask_two_a)
  );

  pgm_mask_reg u_two_b (
    .clk      (MCLK),
    .rstn     (RSTN),
    .load_otp (load_otp),
    .otp_val  (OTP_TWO_B),
    .wr_en    (wr_two_b),
    .wdata    (WDATA),
    .q        (mask_two_b)
  );

  pgm_mask_reg u_three_a (
    .clk      (MCLK),
    .rstn     (RSTN),
    .load_otp (load_otp),
    .otp_val  (OTP_THREE_A),
    .wr_en    (wr_three_a),
    .wdata    (WDATA),
    .q        (mask_three_a)
  );

  // ****************************************************************
  // power good trees
  // ****************************************************************
  pgm_byte_type src_a;
  pgm_byte_type src_b;
  logic         shared_good;
  logic [7:0]   keep_two_a;
  logic [7:0]   keep_two_b;
  logic [7:0]   keep_three_a;
  logic         good_two;
  logic         good_three;

  always_comb begin
    shared_good = (shared_sel_r == PGM_SHARED_LINEAR_A1) ?
                  LINEAR_A1_GOOD : SWITCH_B2_GOOD;
    src_a = `PGM_ZERO;
    src_a[`PGM_BIT_LINEAR_A2]    = LINEAR_A2_GOOD;
    src_a[`PGM_BIT_SWITCH_A1]    = SWITCH_A1_GOOD;
    src_a[`PGM_STEPDOWN_HI:0]    = STEPDOWN_GOOD;
    src_b = `PGM_ZERO;
    // raw pin level, not a regulator flag
    src_b[`PGM_CTL_HI:`PGM_CTL_LO] = CONTROL_IN;
    src_b[`PGM_BIT_TERMINATION]  = TERMINATION_GOOD;
    src_b[`PGM_BIT_SHARED]       = shared_good;
    src_b[`PGM_BIT_SWITCH_B1]    = SWITCH_B1_GOOD;
    src_b[`PGM_BIT_LINEAR_A3]    = LINEAR_A3_GOOD;
  end

  // one bit per source: masked bits are forced good
  for (genvar i = 0; i < `PGM_DW; i++) begin : g_keep
    assign keep_two_a[i]   = src_a[i] | mask_two_a[i];
    assign keep_two_b[i]   = src_b[i] | mask_two_b[i];
    assign keep_three_a[i] = src_a[i] | mask_three_a[i];
  end

  // outputs held low until otp masks are in place
  always_comb begin
    good_two   = loaded_r & (&keep_two_a) & (&keep_two_b);
    good_three = loaded_r & (&keep_three_a);
  end

  logic out_two_r;
  logic out_three_r;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      out_two_r   <= 1'b0;
      out_three_r <= 1'b0;
    end else begin
      out_two_r   <= good_two;
      out_three_r <= good_three;
    end
  end

  assign POWER_GOOD_OUT_TWO   = out_two_r;
  assign POWER_GOOD_OUT_THREE = out_three_r;

  // ****************************************************************
  // register read port
  // ****************************************************************
  pgm_byte_type rdata_r;
  pgm_byte_type rdata_nxt;
  pgm_byte_type status;

  always_comb begin
    status = `PGM_ZERO;
    status[`PGM_ST_GOOD_TWO]   = out_two_r;
    status[`PGM_ST_GOOD_THREE] = out_three_r;
    status[`PGM_ST_SHARED_SEL] = shared_sel_r;
    status[`PGM_ST_LOADED]     = loaded_r;
    rdata_nxt = `PGM_ZERO;
    if (RD && ADDR == `PGM_OFS_TWO_A) begin
      rdata_nxt = mask_two_a;
    end else if (RD && ADDR == `PGM_OFS_TWO_B) begin
      rdata_nxt = mask_two_b;
    end else if (RD && ADDR == `PGM_OFS_THREE_A) begin
      rdata_nxt = mask_three_a;
    end else if (RD && ADDR == `PGM_OFS_STATUS) begin
      rdata_nxt = status;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_r <= `PGM_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  two_a_write_a: assert property (
    loaded_r && WR && ADDR == `PGM_OFS_TWO_A |=>
      mask_two_a == $past(WDATA) && $stable(mask_three_a))
    else $error("pin two mask a write lost");

  two_b_write_a: assert property (
    loaded_r && WR && ADDR == `PGM_OFS_TWO_B |=>
      mask_two_b == $past(WDATA) && $stable(mask_two_a))
    else $error("pin two mask b write lost");

  three_a_write_a: assert property (
    loaded_r && WR && ADDR == `PGM_OFS_THREE_A |=>
      mask_three_a == $past(WDATA) && $stable(mask_two_a))
    else $error("pin three mask a write lost");

  all_masked_a: assert property (
    loaded_r && mask_two_a == `PGM_ALL_MASKED &&
    mask_two_b == `PGM_ALL_MASKED && mask_three_a == `PGM_ALL_MASKED
    |=> POWER_GOOD_OUT_TWO && POWER_GOOD_OUT_THREE)
    else $error("masked sources still affect output");

  control_term_a: assert property (
    loaded_r && mask_two_a == `PGM_ALL_MASKED &&
    mask_two_b == `PGM_CTL_ONLY
    |=> POWER_GOOD_OUT_TWO == (&$past(CONTROL_IN)))
    else $error("control level not in pin two tree");

  shared_slot_a: assert property (
    loaded_r && mask_two_a == `PGM_ALL_MASKED &&
    mask_two_b == `PGM_SHARED_ONLY
    |=> POWER_GOOD_OUT_TWO == $past(shared_sel_r ?
          LINEAR_A1_GOOD : SWITCH_B2_GOOD))
    else $error("shared slot follows wrong source");

  otp_load_a: assert property (
    $rose(loaded_r) |-> mask_two_a == $past(OTP_TWO_A) &&
      mask_two_b == $past(OTP_TWO_B) &&
      mask_three_a == $past(OTP_THREE_A))
    else $error("otp reset values not loaded");

  read_back_a: assert property (
    loaded_r && RD && ADDR == `PGM_OFS_TWO_B && !wr_two_b |=>
      RDATA == mask_two_b)
    else $error("mask read back wrong");

  unmasked_bad_a: assert property (
    (|(~src_a & ~mask_two_a)) || (|(~src_b & ~mask_two_b))
    |=> !POWER_GOOD_OUT_TWO)
    else $error("pin two good with a bad source");

  three_bad_a: assert property (
    loaded_r && (&(src_a | mask_three_a)) ##1 !(&(src_a | mask_three_a))
    |=> !POWER_GOOD_OUT_THREE && $past(POWER_GOOD_OUT_THREE))
    else $error("pin three good with a bad source");

  three_a_read_a: assert property (
    RD && ADDR == `PGM_OFS_THREE_A |=> RDATA == $past(mask_three_a))
    else $error("pin three mask a read back wrong");

  three_good_a: assert property (
    loaded_r && &({LINEAR_A2_GOOD, SWITCH_A1_GOOD, STEPDOWN_GOOD} |
                  mask_three_a)
    |=> POWER_GOOD_OUT_THREE)
    else $error("pin three low with all sources good");

  two_a_map_a: assert property (
    loaded_r && !(&({LINEAR_A2_GOOD, SWITCH_A1_GOOD, STEPDOWN_GOOD} |
                    mask_two_a))
    |=> !POWER_GOOD_OUT_TWO)
    else $error("pin two good with a bad mask a source");

  otp_wins_a: assert property (
    !loaded_r && WR && ADDR == `PGM_OFS_TWO_A |=>
      mask_two_a == $past(OTP_TWO_A))
    else $error("write beat the otp load");

  unmapped_read_a: assert property (
    RD && ADDR != `PGM_OFS_TWO_A && ADDR != `PGM_OFS_TWO_B &&
    ADDR != `PGM_OFS_THREE_A && ADDR != `PGM_OFS_STATUS
    |=> RDATA == `PGM_ZERO)
    else $error("unmapped read not zero");

  rdata_idle_a: assert property (
    !RD |=> RDATA == `PGM_ZERO)
    else $error("read data outside its cycle");

  status_ro_a: assert property (
    loaded_r && WR && ADDR == `PGM_OFS_STATUS |=>
      $stable(mask_two_a) && $stable(mask_two_b) && $stable(mask_three_a))
    else $error("status write changed a mask");

endmodule : pgm_bank

// File: pgm_rail_model.sv
`timescale 1ns/100ps

// ****************************************************************
// far-side rail sources and control pins
// ****************************************************************
// levels move only after a clock edge, like a real
// synchronised rail monitor would present them
module pgm_rail_model (
  input  wire logic        clk,
  input  wire logic [17:0] want,
  output logic [17:0]      src
);
  always_ff @(posedge clk) begin
    src <= want;
  end
endmodule : pgm_rail_model

// File: pgm_bank_test.sv
`timescale 1ns/100ps
`include "pgm_defs.svh"

// ****************************************************************
// bench for the power-good mask bank
// ****************************************************************
module pgm_bank_test
  import pgm_pkg::*;
;
  logic         MCLK, RSTN, WR, RD, sel;
  pgm_byte_type ADDR, WDATA, RDATA, o2a, o2b, o3a;
  logic         out2, out3;
  logic [17:0]  want, src;
  logic [31:0]  seed;
  int           n_mismatch, samples_checked, cyc;

  pgm_rail_model i_rail (.clk(MCLK), .want(want), .src(src));

  pgm_bank i_dut (
    .MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA),
    .OTP_TWO_A(o2a), .OTP_TWO_B(o2b), .OTP_THREE_A(o3a),
    .OTP_SHARED_SEL(sel), .STEPDOWN_GOOD(src[5:0]),
    .LINEAR_A2_GOOD(src[7]), .SWITCH_A1_GOOD(src[6]),
    .LINEAR_A3_GOOD(src[8]), .LINEAR_A1_GOOD(src[16]),
    .SWITCH_B1_GOOD(src[9]), .SWITCH_B2_GOOD(src[17]),
    .TERMINATION_GOOD(src[11]), .CONTROL_IN(src[15:12]),
    .POWER_GOOD_OUT_TWO(out2), .POWER_GOOD_OUT_THREE(out3)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // {three, two}; a set mask bit forces its term good
  function automatic logic [1:0] exp_out(input logic [7:0] ma, mb, m3,
                                        input logic [17:0] s,
                                        input logic sl);
    logic [7:0] gb;
    gb = {s[15:11], sl ? s[16] : s[17], s[9:8]};
    return {&(s[7:0] | m3), &(s[7:0] | ma) & &(gb | mb)};
  endfunction : exp_out

  task automatic chk(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // ample for two resets and sixty mask rounds
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    logic [7:0] ma, mb, m3, d;
    logic [17:0] s;
    logic [1:0]  e;
    seed = 32'hc911228e;
    {RSTN, WR, RD, sel, ADDR, WDATA} = '0;
    {o2a, o2b, o3a, want} = '0;
    for (int k = 0; k < 2; k++) begin
      // second pass resets mid-run with the other slot owner
      @(posedge MCLK);
      RSTN <= 1'b0;
      sel  <= k[0];
      o2a  <= 8'(xs());
      o2b  <= 8'(xs());
      o3a  <= 8'(xs());
      repeat (20) @(posedge MCLK);
      // a write in the load cycle must lose to the otp value
      RSTN  <= 1'b1;
      ADDR  <= `PGM_OFS_TWO_A;
      WDATA <= ~o2a;
      WR    <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      @(posedge MCLK);
      rd(`PGM_OFS_TWO_A, d);   chk("otp two a", o2a, d);
      rd(`PGM_OFS_TWO_B, d);   chk("otp two b", o2b, d);
      rd(`PGM_OFS_THREE_A, d); chk("otp three", o3a, d);
      wr(8'h00, 8'h5a);
      wr(`PGM_OFS_STATUS, 8'hf0);
      rd(8'h00, d);            chk("unmapped", 8'h00, d);
      rd(`PGM_OFS_TWO_A, d);   chk("after unmapped", o2a, d);
      for (int i = 0; i < 30; i++) begin
        ma = 8'(xs() | xs());
        mb = 8'(xs() | xs());
        m3 = 8'(xs() | xs());
        s  = 18'(xs() | xs());
        if (i == 0) {ma, mb, m3, s} = {24'hffffff, 18'h0};
        if (i == 1) {ma, mb, m3, s} = {24'h0, 18'h3ffff};
        // shared slot sources differ, so the owner decides the result
        if (i == 2) {ma, mb, m3, s} = {24'hfffbff, 18'h1ffff};
        if (i == 3) {ma, mb, m3, s} = {24'hff0fff, 18'h3bfff};
        if (i == 4) {ma, mb, m3, s} = {24'hff0fff, 18'h3ffff};
        @(posedge MCLK);
        want <= s;
        wr(`PGM_OFS_TWO_A, ma);
        wr(`PGM_OFS_TWO_B, mb);
        wr(`PGM_OFS_THREE_A, m3);
        rd(`PGM_OFS_TWO_A, d);   chk("mask two a", ma, d);
        rd(`PGM_OFS_TWO_B, d);   chk("mask two b", mb, d);
        rd(`PGM_OFS_THREE_A, d); chk("mask three", m3, d);
        repeat (3) @(posedge MCLK);
        #1;
        e = exp_out(ma, mb, m3, s, k[0]);
        chk("good outputs", {6'h0, e}, {6'h0, out3, out2});
        rd(`PGM_OFS_STATUS, d);
        chk("status", {4'h0, 1'b1, k[0], e}, d);
      end
      $display("test with slot owner %0d done", k);
    end
    conclude();
  end
endmodule : pgm_bank_test
